// [logic/fpm_power_ctrl.sv]
// Power-mode and reset sequencer of a serial flash: active, standby, deep sleep, power-up
// and hardware reset, with the shared data line three acting as reset input.
// Assumes chip select and reset pin arrive asynchronously; opcode, status
// and configuration come from core logic on clk_i, cmd_valid_i a one-cycle pulse.
// Operation
// - Chip select low means selected and in active power state; code goes active only from standby, not in deep sleep, wake, power-up or reset.
// - After deselect stay active while program, erase or write runs; then standby.
// - Deep-sleep opcode puts the device into deep sleep.
// - Deep-sleep opcode accepted only while write-in-progress flag reads zero.
// - In deep sleep only wake opcode is honoured; standby after wake delay.
// - After power-up run reset sequence for power-up delay before operating.
// - Reset pin acts as reset only after deselect time, or when quad bit zero.
// - Reset input ignored throughout the power-on reset sequence.
// - Reset low for pulse width aborts, tristates, blocks commands for hold period.
`timescale 1ns/1ps
`default_nettype none
`include "fpm_regs.svh"
module fpm_power_ctrl
    import fpm_pkg::*;
#(
    parameter int POWERUP_CYC = `FPM_POWERUP_DELAY_CYC,
    parameter int RESET_HOLD_CYC = `FPM_RESET_PULSE_HOLD_CYC,
    parameter int WAKE_CYC = `FPM_WAKE_DELAY_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic chip_select_n_i,
    input wire logic shared_dataline_reset_pin_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_opcode_i,
    input wire logic [7:0] volatile_status_reg_one_i,
    input wire logic [7:0] volatile_config_reg_one_i,
    input wire logic embedded_busy_i,
    output logic active_power_o,
    output logic standby_o,
    output logic deep_sleep_mode_o,
    output logic powerup_busy_o,
    output logic hw_reset_o,
    output logic abort_o,
    output logic outputs_tristate_o,
    output logic cmd_enable_o,
    output logic reset_input_enabled_o
);
    localparam int DESEL_CYC = `FPM_DESELECT_CYC;
    localparam int PULSE_CYC = `FPM_RESET_PULSE_CYC;

    logic cs_n_s;
    logic rst_pin_s;
    fpm_state_type state;
    fpm_state_type next_state;
    logic [31:0] timer;
    logic [31:0] next_timer;
    logic [7:0] desel_cnt;
    logic [7:0] next_desel_cnt;
    logic [7:0] low_cnt;
    logic [7:0] next_low_cnt;
    logic next_active;
    logic next_standby;
    logic next_deep;
    logic next_pu;
    logic next_hwr;
    logic next_abort;
    logic next_cmd_en;
    logic next_rst_en;
    logic busy;
    logic rst_en;
    logic reset_fire;

    fpm_sync #(.RESET_VALUE(1'b1)) u_cs_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(chip_select_n_i),
        .sync_o(cs_n_s)
    );

    fpm_sync #(.RESET_VALUE(1'b1)) u_rst_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(shared_dataline_reset_pin_i),
        .sync_o(rst_pin_s)
    );

    always_comb begin
        busy = embedded_busy_i | volatile_status_reg_one_i[`FPM_STATUS_WIP_BIT];
        // Reset pin is a reset input after the deselect time or outside quad mode.
        rst_en = (cs_n_s && (desel_cnt >= 8'(DESEL_CYC)))
            || !volatile_config_reg_one_i[`FPM_CFG_QUAD_BIT];
        reset_fire = rst_en && (low_cnt >= 8'(PULSE_CYC)) && (state != FPM_POWERUP)
            && (state != FPM_HW_RESET);
        next_desel_cnt = cs_n_s ? ((desel_cnt == 8'hFF) ? desel_cnt : desel_cnt + 8'h01)
            : 8'h00;
        next_low_cnt = (!rst_pin_s && rst_en)
            ? ((low_cnt == 8'hFF) ? low_cnt : low_cnt + 8'h01) : 8'h00;
        next_state = state;
        next_timer = (timer == 32'h0) ? timer : timer - 32'h1;
        case (state)
            FPM_POWERUP: begin
                // Power-up runs for its full delay and ignores the reset pin.
                if (timer == 32'h0) begin
                    next_state = FPM_STANDBY;
                end
            end
            FPM_STANDBY: begin
                if (reset_fire) begin
                    next_state = FPM_HW_RESET;
                    next_timer = 32'(RESET_HOLD_CYC);
                end else if (cmd_valid_i && cmd_opcode_i == `FPM_CMD_DEEP_SLEEP
                        && !busy) begin
                    next_state = FPM_DEEP_SLEEP;
                end else if (!cs_n_s || busy) begin
                    next_state = FPM_ACTIVE;
                end
            end
            FPM_ACTIVE: begin
                if (reset_fire) begin
                    next_state = FPM_HW_RESET;
                    next_timer = 32'(RESET_HOLD_CYC);
                end else if (cmd_valid_i && cmd_opcode_i == `FPM_CMD_DEEP_SLEEP
                        && !busy) begin
                    next_state = FPM_DEEP_SLEEP;
                end else if (cs_n_s && !busy) begin
                    next_state = FPM_STANDBY;
                end
            end
            FPM_DEEP_SLEEP: begin
                if (reset_fire) begin
                    next_state = FPM_HW_RESET;
                    next_timer = 32'(RESET_HOLD_CYC);
                end else if (cmd_valid_i && cmd_opcode_i == `FPM_CMD_WAKE) begin
                    next_state = FPM_WAKING;
                    next_timer = 32'(WAKE_CYC);
                end
            end
            FPM_WAKING: begin
                if (reset_fire) begin
                    next_state = FPM_HW_RESET;
                    next_timer = 32'(RESET_HOLD_CYC);
                end else if (timer == 32'h0) begin
                    next_state = FPM_STANDBY;
                end
            end
            FPM_HW_RESET: begin
                if (timer == 32'h0) begin
                    next_state = FPM_STANDBY;
                end
            end
            default: begin
                next_state = FPM_POWERUP;
                next_timer = 32'(POWERUP_CYC);
            end
        endcase
        next_active = (next_state == FPM_ACTIVE);
        next_standby = (next_state == FPM_STANDBY);
        next_deep = (next_state == FPM_DEEP_SLEEP) || (next_state == FPM_WAKING);
        next_pu = (next_state == FPM_POWERUP);
        next_hwr = (next_state == FPM_HW_RESET);
        next_abort = reset_fire && (state != FPM_HW_RESET);
        next_cmd_en = (next_state == FPM_STANDBY) || (next_state == FPM_ACTIVE);
        next_rst_en = rst_en && (next_state != FPM_POWERUP);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= FPM_POWERUP;
            timer <= 32'(POWERUP_CYC);
            desel_cnt <= 8'h00;
            low_cnt <= 8'h00;
            active_power_o <= 1'b0;
            standby_o <= 1'b0;
            deep_sleep_mode_o <= 1'b0;
            powerup_busy_o <= 1'b1;
            hw_reset_o <= 1'b0;
            abort_o <= 1'b0;
            outputs_tristate_o <= 1'b1;
            cmd_enable_o <= 1'b0;
            reset_input_enabled_o <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            desel_cnt <= next_desel_cnt;
            low_cnt <= next_low_cnt;
            active_power_o <= next_active;
            standby_o <= next_standby;
            deep_sleep_mode_o <= next_deep;
            powerup_busy_o <= next_pu;
            hw_reset_o <= next_hwr;
            abort_o <= next_abort;
            outputs_tristate_o <= next_hwr || next_pu;
            cmd_enable_o <= next_cmd_en;
            reset_input_enabled_o <= next_rst_en;
        end
    end

    powerup_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(powerup_busy_o) |-> $past(timer == 32'h0))
        else $error("Power-up ended early.");
    active_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == FPM_STANDBY && !cs_n_s && !reset_fire && !cmd_valid_i)
        |=> state == FPM_ACTIVE)
        else $error("Selected device not active.");
    busy_stay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == FPM_ACTIVE && busy && !reset_fire) |=> state == FPM_ACTIVE)
        else $error("Left active while busy.");
    sleep_enter_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state inside {FPM_STANDBY, FPM_ACTIVE} && cmd_valid_i
        && cmd_opcode_i == `FPM_CMD_DEEP_SLEEP && !busy && !reset_fire) |=> deep_sleep_mode_o)
        else $error("Deep sleep not entered.");
    sleep_refuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state != FPM_DEEP_SLEEP && busy && !reset_fire && state != FPM_WAKING)
        |=> state != FPM_DEEP_SLEEP)
        else $error("Deep sleep entered while busy.");
    sleep_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == FPM_DEEP_SLEEP && !reset_fire
        && !(cmd_valid_i && cmd_opcode_i == `FPM_CMD_WAKE)) |=> state == FPM_DEEP_SLEEP)
        else $error("Deep sleep left without wake.");
    sequence wake_req_s;
        state == FPM_DEEP_SLEEP && cmd_valid_i && cmd_opcode_i == `FPM_CMD_WAKE && !reset_fire;
    endsequence
    sequence wake_run_s;
        state == FPM_WAKING && deep_sleep_mode_o && !standby_o;
    endsequence
    wake_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_req_s |=> wake_run_s)
        else $error("Wake not started.");
    por_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == FPM_POWERUP) |=> state inside {FPM_POWERUP, FPM_STANDBY})
        else $error("Reset acted during power-up.");
    reset_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == FPM_ACTIVE && !rst_en) |=> state != FPM_HW_RESET)
        else $error("Reset taken while pin is data.");
    hw_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == FPM_HW_RESET) |-> (!cmd_enable_o && outputs_tristate_o && hw_reset_o))
        else $error("Commands enabled during reset hold.");
endmodule : fpm_power_ctrl
`default_nettype wire

// [logic/fpm_regs.svh]
// Timing constants and command codes for the flash power-mode and reset sequencer.
// Assumes a 10 MHz core clock; counts are derived from times in nanoseconds.
`ifndef FPM_REGS_SVH
`define FPM_REGS_SVH
`define FPM_CLK_PERIOD_NS 100
`define FPM_CMD_DEEP_SLEEP 8'hB9
`define FPM_CMD_WAKE 8'hAB
`define FPM_CFG_QUAD_BIT 1
`define FPM_STATUS_WIP_BIT 0
`define FPM_DESELECT_TIME_NS 50
`define FPM_DESELECT_CYC ((`FPM_DESELECT_TIME_NS + `FPM_CLK_PERIOD_NS - 1) / `FPM_CLK_PERIOD_NS)
`define FPM_RESET_PULSE_WIDTH_NS 200
`define FPM_RESET_PULSE_CYC ((`FPM_RESET_PULSE_WIDTH_NS + `FPM_CLK_PERIOD_NS - 1) / `FPM_CLK_PERIOD_NS)
`define FPM_RESET_PULSE_HOLD_NS 35000
`define FPM_RESET_PULSE_HOLD_CYC ((`FPM_RESET_PULSE_HOLD_NS + `FPM_CLK_PERIOD_NS - 1) / `FPM_CLK_PERIOD_NS)
`define FPM_POWERUP_DELAY_NS 300000
`define FPM_POWERUP_DELAY_CYC ((`FPM_POWERUP_DELAY_NS + `FPM_CLK_PERIOD_NS - 1) / `FPM_CLK_PERIOD_NS)
`define FPM_WAKE_DELAY_NS 30000
`define FPM_WAKE_DELAY_CYC ((`FPM_WAKE_DELAY_NS + `FPM_CLK_PERIOD_NS - 1) / `FPM_CLK_PERIOD_NS)
`endif

// [logic/fpm_pkg.sv]
// Types for the flash power-mode and reset sequencer.
// Assumes nothing beyond the constants header.
package fpm_pkg;
    typedef enum logic [2:0] {
        FPM_POWERUP = 3'h0,
        FPM_STANDBY = 3'h1,
        FPM_ACTIVE = 3'h2,
        FPM_DEEP_SLEEP = 3'h3,
        FPM_WAKING = 3'h4,
        FPM_HW_RESET = 3'h5
    } fpm_state_type;
endpackage : fpm_pkg

// [logic/fpm_sync.sv]
// Two flip-flop synchroniser for a level coming from outside the clock domain.
// Assumes the level is stable for several core clock periods.
`timescale 1ns/1ps
`default_nettype none
module fpm_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic sync_o
);
    logic meta;
    logic next_meta;
    logic next_sync;

    always_comb begin
        next_meta = async_i;
        next_sync = meta;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= RESET_VALUE;
            sync_o <= RESET_VALUE;
        end else begin
            meta <= next_meta;
            sync_o <= next_sync;
        end
    end
endmodule : fpm_sync
`default_nettype wire

// [sim/fpm_host_model.sv]
// Host-side model that drives chip select and the shared data line three reset pin.
// Assumes its tasks are called from the bench and that it changes pins at falling edges.
`timescale 1ns/1ps
`default_nettype none
module fpm_host_model (
    input wire logic clk_i,
    output logic chip_select_n_o,
    output logic reset_pin_n_o
);
    initial begin
        chip_select_n_o = 1'b1;
        reset_pin_n_o = 1'b1;
    end
    task automatic select_dev();
        repeat (2) @(negedge clk_i);
        chip_select_n_o = 1'b0;
    endtask : select_dev
    task automatic deselect_dev();
        @(negedge clk_i);
        chip_select_n_o = 1'b1;
    endtask : deselect_dev
    task automatic pulse_reset(input int cyc);
        repeat (2) @(negedge clk_i);
        reset_pin_n_o = 1'b0;
        repeat (cyc) @(negedge clk_i);
        reset_pin_n_o = 1'b1;
    endtask : pulse_reset
endmodule : fpm_host_model
`default_nettype wire

// [sim/fpm_power_ctrl_bench.sv]
// Self-checking bench for the power-mode and reset sequencer.
// Assumes shortened counts and a host model that drives the pins.
`timescale 1ns/1ps
`default_nettype none
module fpm_power_ctrl_bench;
    import fpm_pkg::*;
    localparam int PU = 20;
    localparam int RH = 10;
    localparam int WK = 10;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cs_n, rpin_n, act, sb, ds, pub, hwr, abrt, tri_o, cen, rie;
    logic cmd_valid = 1'b0;
    logic busy = 1'b0;
    logic abort_seen = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic [7:0] status = 8'h00;
    logic [7:0] config_r = 8'h00;
    int mismatches = 0;
    int compares = 0;
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) if (abrt === 1'b1) abort_seen <= 1'b1;
    fpm_host_model host_u (.clk_i(clk_i), .chip_select_n_o(cs_n), .reset_pin_n_o(rpin_n));
    fpm_power_ctrl #(.POWERUP_CYC(PU), .RESET_HOLD_CYC(RH), .WAKE_CYC(WK)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .chip_select_n_i(cs_n),
        .shared_dataline_reset_pin_i(rpin_n), .cmd_valid_i(cmd_valid),
        .cmd_opcode_i(opcode), .volatile_status_reg_one_i(status),
        .volatile_config_reg_one_i(config_r), .embedded_busy_i(busy),
        .active_power_o(act), .standby_o(sb), .deep_sleep_mode_o(ds),
        .powerup_busy_o(pub), .hw_reset_o(hwr), .abort_o(abrt),
        .outputs_tristate_o(tri_o), .cmd_enable_o(cen), .reset_input_enabled_o(rie));
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic exp, input logic seen);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    task automatic wait_standby(input int lim);
        int n;
        n = 0;
        while (sb !== 1'b1 && n < lim) begin
            @(negedge clk_i);
            n++;
        end
        if (sb !== 1'b1) begin
            mismatches++;
            $display("BAD standby wait expected 1 seen %b", sb);
            test_done();
        end
    endtask : wait_standby
    task automatic send_cmd(input logic [7:0] op);
        @(negedge clk_i);
        cmd_valid = 1'b1;
        opcode = op;
        @(negedge clk_i);
        cmd_valid = 1'b0;
    endtask : send_cmd
    task automatic t_powerup();
        check("powerup busy", 1'b1, pub);
        check("powerup tristate", 1'b1, tri_o);
        host_u.pulse_reset(4);
        repeat (2) @(negedge clk_i);
        check("reset during powerup", 1'b0, hwr);
        repeat (PU - 12) @(negedge clk_i);
        check("standby early", 1'b0, sb);
        wait_standby(8);
        check("powerup done", 1'b0, pub);
    endtask : t_powerup
    task automatic t_active();
        host_u.select_dev();
        repeat (4) @(negedge clk_i);
        check("active on select", 1'b1, act);
        check("pin on outside quad", 1'b1, rie);
        busy = 1'b1;
        host_u.deselect_dev();
        repeat (5) @(negedge clk_i);
        check("active while busy", 1'b1, act);
        check("standby while busy", 1'b0, sb);
        busy = 1'b0;
        repeat (3) @(negedge clk_i);
        check("standby after busy", 1'b1, sb);
    endtask : t_active
    task automatic t_sleep();
        status = 8'h01;
        send_cmd(8'hB9);
        repeat (3) @(negedge clk_i);
        check("sleep refused", 1'b0, ds);
        status = 8'h00;
        send_cmd(8'hB9);
        repeat (2) @(negedge clk_i);
        check("sleep entered", 1'b1, ds);
        send_cmd(8'h06);
        repeat (WK + 4) @(negedge clk_i);
        check("other cmd ignored", 1'b0, sb);
        send_cmd(8'hAB);
        repeat (2) @(negedge clk_i);
        check("wake delay", 1'b1, ds);
        repeat (WK - 4) @(negedge clk_i);
        check("standby before wake delay", 1'b0, sb);
        wait_standby(WK + 4);
        check("awake", 1'b0, ds);
    endtask : t_sleep
    task automatic t_reset();
        config_r = 8'h02;
        host_u.select_dev();
        repeat (3) @(negedge clk_i);
        check("pin off when selected", 1'b0, rie);
        host_u.pulse_reset(4);
        repeat (3) @(negedge clk_i);
        check("no reset when selected", 1'b0, hwr);
        host_u.deselect_dev();
        repeat (4) @(negedge clk_i);
        check("pin on after deselect", 1'b1, rie);
        host_u.pulse_reset(4);
        repeat (2) @(negedge clk_i);
        check("hw reset", 1'b1, hwr);
        check("reset tristate", 1'b1, tri_o);
        check("cmds blocked", 1'b0, cen);
        check("abort pulse", 1'b1, abort_seen);
        send_cmd(8'hB9);
        wait_standby(RH + 6);
        check("cmd during reset", 1'b0, ds);
        check("cmds open after reset", 1'b1, cen);
    endtask : t_reset
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        test_done();
    end
    initial begin
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        t_powerup();
        t_active();
        t_sleep();
        t_reset();
        test_done();
    end
endmodule : fpm_power_ctrl_bench
`default_nettype wire
